/* File: hdl/ipc_input_protect.sv */
// Behaviour
// - Every access to the four commands affects both channels, page ignored.
// - Overvoltage and undervoltage action bytes are read-only, byte reads only.
// - Undervoltage and overcurrent limits are 16-bit linear, word access only.
// - Input OV or UV fault sets OTHER, INPUT and the matching input status bit.
// - Input OV fault raises the host alert unless its mask bit is set.
// - OV action reads 00h: flag and alert, keep converting.
// - UV detection stays masked until input passes turn-on and unit is enabled.
// - UV limit exponent and mantissa writable, NVM-loaded, F80Dh..F817h in 1 V steps.
// - Input UV fault raises the host alert unless its mask bit is set.
// - UV action reads C0h: shut down, restart once the condition clears.
// - Input overcurrent fault when sensed current crosses the overcurrent limit.
// - Overcurrent exponent is read-only 11111b, giving 0.5 A steps.
// - Overcurrent mantissa writable, valid 0 to 127.
// - Valid overcurrent limit written in operation takes effect at once.
// - Reset or restore reloads stored OC limit only if listed, else 63.5 A.
// - Turn-on threshold starts conversion and gates UV masking.
//
`timescale 1ns/1ps
`default_nettype none
module ipc_input_protect (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_is_word,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic restore_all,
  input wire logic [15:0] nvm_uv_limit,
  input wire logic [15:0] nvm_oc_limit,
  input wire logic [15:0] vin_on_code,
  input wire logic [15:0] vin_sense_q,
  input wire logic [15:0] iin_sense_q,
  input wire logic vin_ov_detect,
  input wire logic unit_enable,
  input wire logic mask_vin_ov,
  input wire logic mask_vin_uv,
  input wire logic mask_iin_oc,
  input wire logic status_clear,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata,
  output logic [15:0] uv_limit_out,
  output logic [15:0] oc_limit_out,
  output logic status_other,
  output logic status_input,
  output logic input_vin_ov_fault,
  output logic input_vin_uv_fault,
  output logic input_iin_oc_fault,
  output logic host_alert_out,
  output logic convert_enable
);
  import ipc_pkg::*;

  // ****************************************************************
  // State record.
  // ****************************************************************
  typedef struct packed {
    ipc_pwr_t pwr;
    logic [15:0] uv_lim;
    logic [15:0] oc_lim;
    logic load_pend;
    logic uv_armed;
    logic ov_f;
    logic uv_f;
    logic oc_f;
    logic other_f;
    logic input_f;
    logic alert;
    logic conv_en;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
  } ipc_state_t;

  localparam ipc_state_t STATE_RST = '{
    pwr: PWR_IDLE,
    uv_lim: UV_LIMIT_RST,
    oc_lim: OC_LIMIT_RST,
    load_pend: 1'b1,
    uv_armed: 1'b0,
    ov_f: 1'b0,
    uv_f: 1'b0,
    oc_f: 1'b0,
    other_f: 1'b0,
    input_f: 1'b0,
    alert: 1'b0,
    conv_en: 1'b0,
    rsp_valid: 1'b0,
    rsp_err: 1'b0,
    rsp_data: 16'h0000
  };

  ipc_state_t st_q;
  ipc_state_t st_d;

  // ****************************************************************
  // Encoding checks.
  // ****************************************************************

  // Undervoltage limit: odd codes in the window are the whole-volt steps.
  function automatic logic uv_code_ok(input logic [15:0] v);
    uv_code_ok = (v >= UV_LIMIT_MIN) && (v <= UV_LIMIT_MAX) && v[0];
  endfunction

  // Stored overcurrent limit survives a reload only on the listed codes.
  function automatic logic [15:0] oc_reload(input logic [15:0] v);
    if (((v >= OC_NVM_MIN) && (v <= OC_NVM_MAX) && (v[3:0] == OC_NVM_STEP_LOW))
        || (v == OC_LIMIT_RST)) begin
      oc_reload = v;
    end else begin
      oc_reload = OC_LIMIT_RST;
    end
  endfunction

  // ****************************************************************
  // Comparators.
  // ****************************************************************
  logic vin_above_on;
  logic vin_below_uv;
  logic iin_above_oc;

  // Turn-on threshold crossing gates both start-up and UV masking.
  ipc_lin_cmp u_cmp_on (
    .limit_code(vin_on_code),
    .sense_q(vin_sense_q),
    .above(vin_above_on),
    .below()
  );

  // Undervoltage compare against the programmed limit.
  ipc_lin_cmp u_cmp_uv (
    .limit_code(st_q.uv_lim),
    .sense_q(vin_sense_q),
    .above(),
    .below(vin_below_uv)
  );

  // Overcurrent compare against the programmed limit.
  ipc_lin_cmp u_cmp_oc (
    .limit_code(st_q.oc_lim),
    .sense_q(iin_sense_q),
    .above(iin_above_oc),
    .below()
  );

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  logic ov_evt;
  logic uv_evt;
  logic oc_evt;

  always_comb begin
    st_d = st_q;
    ov_evt = vin_ov_detect;
    uv_evt = st_q.uv_armed && vin_below_uv;
    oc_evt = iin_above_oc;

    // The mask arms once and stays armed; a later dip below turn-on must still fault.
    if (unit_enable && vin_above_on) begin
      st_d.uv_armed = 1'b1;
    end

    // Command port: no page input exists, so every access hits the one shared copy.
    st_d.rsp_valid = cmd_valid;
    st_d.rsp_err = 1'b0;
    st_d.rsp_data = 16'h0000;
    if (cmd_valid) begin
      case (cmd_code)
        CMD_VIN_OV_ACTION: begin
          // Byte read only; writes and word accesses are refused, byte unchanged.
          if (cmd_write || cmd_is_word) begin
            st_d.rsp_err = 1'b1;
          end else begin
            st_d.rsp_data = {8'h00, OV_ACTION_RST};
          end
        end
        CMD_VIN_UV_ACTION: begin
          if (cmd_write || cmd_is_word) begin
            st_d.rsp_err = 1'b1;
          end else begin
            st_d.rsp_data = {8'h00, UV_ACTION_RST};
          end
        end
        CMD_VIN_UV_THRESH: begin
          if (!cmd_is_word) begin
            st_d.rsp_err = 1'b1;
          end else if (!cmd_write) begin
            st_d.rsp_data = st_q.uv_lim;
          end else if (uv_code_ok(cmd_wdata)) begin
            st_d.uv_lim = cmd_wdata;
          end else begin
            st_d.rsp_err = 1'b1;
          end
        end
        CMD_IIN_OC_THRESH: begin
          if (!cmd_is_word) begin
            st_d.rsp_err = 1'b1;
          end else if (!cmd_write) begin
            st_d.rsp_data = st_q.oc_lim;
          end else if (cmd_wdata[MAN_MSB:MAN_LSB] <= OC_MAN_MAX) begin
            // Exponent bits of the write are dropped; the new limit acts next cycle.
            st_d.oc_lim = {OC_EXP_FIXED, cmd_wdata[MAN_MSB:MAN_LSB]};
          end else begin
            st_d.rsp_err = 1'b1;
          end
        end
        default: begin
          st_d.rsp_err = 1'b1;
        end
      endcase
    end

    // Reload from storage after reset release or on restore; it overrides a same-cycle write.
    if (st_q.load_pend || restore_all) begin
      st_d.uv_lim = nvm_uv_limit;
      st_d.oc_lim = oc_reload(nvm_oc_limit);
      st_d.load_pend = 1'b0;
    end

    // Sticky status: clear first, then set, so a fault in the clear cycle is kept.
    if (status_clear) begin
      st_d.ov_f = 1'b0;
      st_d.uv_f = 1'b0;
      st_d.oc_f = 1'b0;
      st_d.other_f = 1'b0;
      st_d.input_f = 1'b0;
    end
    if (ov_evt) begin
      st_d.ov_f = 1'b1;
    end
    if (uv_evt) begin
      st_d.uv_f = 1'b1;
    end
    if (oc_evt) begin
      st_d.oc_f = 1'b1;
    end
    if (ov_evt || uv_evt || oc_evt) begin
      st_d.other_f = 1'b1;
      st_d.input_f = 1'b1;
    end

    // Alert follows the unmasked sticky flags.
    st_d.alert = (st_d.ov_f && !mask_vin_ov)
                 || (st_d.uv_f && !mask_vin_uv)
                 || (st_d.oc_f && !mask_iin_oc);

    // Power sequencing; an overvoltage never leaves the run state.
    case (st_q.pwr)
      PWR_IDLE: begin
        if (unit_enable && vin_above_on) begin
          st_d.pwr = PWR_RUN;
        end
      end
      PWR_RUN: begin
        if (!unit_enable) begin
          st_d.pwr = PWR_IDLE;
        end else if (uv_evt) begin
          st_d.pwr = PWR_UV_OFF;
        end
      end
      PWR_UV_OFF: begin
        if (!unit_enable) begin
          st_d.pwr = PWR_IDLE;
        end else if (!vin_below_uv) begin
          st_d.pwr = PWR_RUN;
        end
      end
      default: begin
        st_d.pwr = PWR_IDLE;
      end
    endcase
    st_d.conv_en = (st_d.pwr == PWR_RUN);
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs all come straight from the state register.
  assign rsp_valid = st_q.rsp_valid;
  assign rsp_err = st_q.rsp_err;
  assign rsp_rdata = st_q.rsp_data;
  assign uv_limit_out = st_q.uv_lim;
  assign oc_limit_out = st_q.oc_lim;
  assign status_other = st_q.other_f;
  assign status_input = st_q.input_f;
  assign input_vin_ov_fault = st_q.ov_f;
  assign input_vin_uv_fault = st_q.uv_f;
  assign input_iin_oc_fault = st_q.oc_f;
  assign host_alert_out = st_q.alert;
  assign convert_enable = st_q.conv_en;
endmodule
`default_nettype wire

/* File: hdl/ipc_pkg.sv */
package ipc_pkg;

  // ****************************************************************
  // Command codes of the shared input-protection registers.
  // ****************************************************************
  localparam logic [7:0] CMD_VIN_OV_ACTION = 8'h56;
  localparam logic [7:0] CMD_VIN_UV_THRESH = 8'h59;
  localparam logic [7:0] CMD_VIN_UV_ACTION = 8'h5a;
  localparam logic [7:0] CMD_IIN_OC_THRESH = 8'h5b;

  // ****************************************************************
  // Linear-format field positions.
  // ****************************************************************
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam int MAN_LSB = 0;

  // Sensed values carry this many fraction bits (LSB = 0.25 V or 0.25 A).
  localparam int SENSE_FRAC_BITS = 2;

  // ****************************************************************
  // Reset values and accepted encodings.
  // ****************************************************************
  localparam logic [7:0] OV_ACTION_RST = 8'h00;
  localparam logic [7:0] UV_ACTION_RST = 8'hc0;
  localparam logic [15:0] UV_LIMIT_RST = 16'hf80d;
  localparam logic [15:0] UV_LIMIT_MIN = 16'hf80d;
  localparam logic [15:0] UV_LIMIT_MAX = 16'hf817;
  localparam logic [15:0] OC_LIMIT_RST = 16'hf87f;
  localparam logic [4:0] OC_EXP_FIXED = 5'h1f;
  localparam logic [10:0] OC_MAN_MAX = 11'h07f;
  localparam logic [15:0] OC_NVM_MIN = 16'hf810;
  localparam logic [15:0] OC_NVM_MAX = 16'hf870;
  localparam logic [3:0] OC_NVM_STEP_LOW = 4'h0;

  // ****************************************************************
  // Power-conversion states.
  // ****************************************************************
  typedef enum logic [2:0] {
    PWR_IDLE = 3'b001,
    PWR_RUN = 3'b010,
    PWR_UV_OFF = 3'b100
  } ipc_pwr_t;

endpackage

/* File: hdl/ipc_lin_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
// Compares a sensed quantity against a linear-format limit.
module ipc_lin_cmp (
  input wire logic [15:0] limit_code,
  input wire logic [15:0] sense_q,
  output logic above,
  output logic below
);
  import ipc_pkg::*;

  logic signed [31:0] man_ext;
  logic signed [5:0] shift_s;
  logic signed [31:0] limit_q;
  logic signed [31:0] sense_ext;

  // Scale mantissa by 2^(exponent + fraction bits); negative shifts truncate toward minus.
  always_comb begin
    man_ext = {{21{limit_code[MAN_MSB]}}, limit_code[MAN_MSB:MAN_LSB]};
    shift_s = $signed({limit_code[EXP_MSB], limit_code[EXP_MSB:EXP_LSB]})
              + 6'(SENSE_FRAC_BITS);
    if (shift_s[5]) begin
      limit_q = man_ext >>> 6'(-shift_s);
    end else begin
      limit_q = man_ext <<< shift_s;
    end
    sense_ext = {16'h0000, sense_q};
    above = sense_ext > limit_q;
    below = sense_ext < limit_q;
  end
endmodule
`default_nettype wire

/* File: dv/ipc_input_protect_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_is_word,
  input wire logic [7:0] cmd_code,
  input wire logic vin_ov_detect,
  input wire logic mask_vin_ov,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata,
  input wire logic [15:0] oc_limit_out,
  input wire logic input_vin_ov_fault,
  input wire logic status_other,
  input wire logic status_input,
  input wire logic host_alert_out
);
  import ipc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Byte reads decoded once; both action registers share it.
  logic rdb;
  assign rdb = cmd_valid && !cmd_write && !cmd_is_word;
  // ****
  // Command port.
  // ****
  a_rsp_next: assert property (cmd_valid |=> rsp_valid)
    else $error("missing answer");
  a_rsp_quiet: assert property (!cmd_valid |=> !rsp_valid)
    else $error("stray answer");
  a_ro_refuse: assert property (cmd_valid && cmd_write &&
    (cmd_code == CMD_VIN_OV_ACTION || cmd_code == CMD_VIN_UV_ACTION) |=> rsp_err)
    else $error("write to read-only accepted");
  a_byte_refuse: assert property (cmd_valid && !cmd_is_word &&
    (cmd_code == CMD_VIN_UV_THRESH || cmd_code == CMD_IIN_OC_THRESH) |=> rsp_err)
    else $error("byte access to limit accepted");
  a_uv_code: assert property (rdb && cmd_code == CMD_VIN_UV_ACTION
    |=> rsp_rdata == 16'h00c0 && !rsp_err) else $error("bad uv action byte");
  a_ov_code: assert property (rdb && cmd_code == CMD_VIN_OV_ACTION
    |=> rsp_rdata == 16'h0000 && !rsp_err) else $error("bad ov action byte");
  // ****
  // Status, alert and OC exponent; covers.
  // ****
  a_ov_flags: assert property (vin_ov_detect
    |=> input_vin_ov_fault && status_other && status_input) else $error("ov flags");
  a_ov_alert: assert property (vin_ov_detect && !mask_vin_ov |=> host_alert_out)
    else $error("ov alert missing");
  a_oc_exp: assert property (oc_limit_out[15:11] == OC_EXP_FIXED)
    else $error("oc exponent changed");
  c_ov_alert: cover property (vin_ov_detect && !mask_vin_ov);
  c_refused: cover property (rsp_valid && rsp_err);
  c_ov_masked: cover property (vin_ov_detect && mask_vin_ov);
endmodule
bind ipc_input_protect ipc_chk ipc_chk_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .cmd_valid(cmd_valid),
  .cmd_write(cmd_write),
  .cmd_is_word(cmd_is_word),
  .cmd_code(cmd_code),
  .vin_ov_detect(vin_ov_detect),
  .mask_vin_ov(mask_vin_ov),
  .rsp_valid(rsp_valid),
  .rsp_err(rsp_err),
  .rsp_rdata(rsp_rdata),
  .oc_limit_out(oc_limit_out),
  .input_vin_ov_fault(input_vin_ov_fault),
  .status_other(status_other),
  .status_input(status_input),
  .host_alert_out(host_alert_out)
);
`default_nettype wire

/* File: dv/ipc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_host_model (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_is_word,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_is_word = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One command; byte or word as the caller asks, held to the taking edge.
  // Released code and data are inverted so a design cannot lean on stale values.
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
    input logic [15:0] d, output logic e, output logic [15:0] q);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_is_word = wd;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge clk_sys);
    #1;
    e = (rsp_valid === 1'b1) ? rsp_err : 1'bx;
    q = rsp_rdata;
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_ipc_input_protect.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ipc_input_protect;
  import ipc_pkg::*;
  logic clk_sys = 0, rst = 1, restore_all = 0, vin_ov_detect = 0, unit_enable = 0;
  logic mask_vin_ov = 0, mask_vin_uv = 0, mask_iin_oc = 0, status_clear = 0;
  logic [15:0] nvm_uv_limit = 16'hf813, nvm_oc_limit = 16'hf845, vin_on_code = 16'hf01d;
  logic [15:0] vin_sense_q = 0, iin_sense_q = 0;
  logic cmd_valid, cmd_write, cmd_is_word, rsp_valid, rsp_err, status_other, status_input;
  logic input_vin_ov_fault, input_vin_uv_fault, input_iin_oc_fault, host_alert_out;
  logic convert_enable;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, uv_limit_out, oc_limit_out;
  int err_count = 0, samples_checked = 0;
  ipc_input_protect ipc_input_protect_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_is_word(cmd_is_word),
    .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata),
    .restore_all(restore_all),
    .nvm_uv_limit(nvm_uv_limit),
    .nvm_oc_limit(nvm_oc_limit),
    .vin_on_code(vin_on_code),
    .vin_sense_q(vin_sense_q),
    .iin_sense_q(iin_sense_q),
    .vin_ov_detect(vin_ov_detect),
    .unit_enable(unit_enable),
    .mask_vin_ov(mask_vin_ov),
    .mask_vin_uv(mask_vin_uv),
    .mask_iin_oc(mask_iin_oc),
    .status_clear(status_clear),
    .rsp_valid(rsp_valid),
    .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata),
    .uv_limit_out(uv_limit_out),
    .oc_limit_out(oc_limit_out),
    .status_other(status_other),
    .status_input(status_input),
    .input_vin_ov_fault(input_vin_ov_fault),
    .input_vin_uv_fault(input_vin_uv_fault),
    .input_iin_oc_fault(input_iin_oc_fault),
    .host_alert_out(host_alert_out),
    .convert_enable(convert_enable)
  );
  ipc_host_model ipc_host_model_i (
    .clk_sys(clk_sys),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_is_word(cmd_is_word),
    .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid),
    .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata)
  );
  // Free-running system clock, 8 ns period.
  always #4 clk_sys = ~clk_sys;
  // ****
  // Helpers.
  // ****
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cmd(input logic w, input logic wd, input logic [7:0] c,
    input logic [15:0] d, input logic [15:0] xe, input logic [15:0] xq);
    logic e;
    logic [15:0] q;
    ipc_host_model_i.xfer(w, wd, c, d, e, q);
    chk("refusal", xe, 16'(e));
    chk("read data", xq, q);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #100us;
    err_count++;
    complete_run();
  end
  // ****
  // Main sequence.
  // ****
  initial begin
    step(20);
    rst = 0;
    step(2);
    chk("uv load", 16'hf813, uv_limit_out);
    chk("oc load", 16'hf87f, oc_limit_out);
    cmd(0, 0, CMD_VIN_OV_ACTION, 0, 0, 16'h0000);
    cmd(0, 0, CMD_VIN_UV_ACTION, 0, 0, 16'h00c0);
    cmd(1, 0, CMD_VIN_OV_ACTION, 16'h00ff, 1, 0);
    cmd(0, 1, CMD_VIN_UV_ACTION, 0, 1, 0);
    cmd(0, 0, CMD_VIN_UV_THRESH, 0, 1, 0);
    cmd(0, 0, 8'h57, 0, 1, 0);
    cmd(1, 1, CMD_VIN_UV_THRESH, 16'hf810, 1, 0);
    cmd(1, 1, CMD_IIN_OC_THRESH, 16'hf880, 1, 0);
    cmd(0, 1, CMD_VIN_UV_THRESH, 0, 0, 16'hf813);
    cmd(1, 1, CMD_IIN_OC_THRESH, 16'h007f, 0, 0);
    cmd(0, 1, CMD_IIN_OC_THRESH, 0, 0, 16'hf87f);
    cmd(1, 1, CMD_IIN_OC_THRESH, 16'h0005, 0, 0);
    cmd(0, 1, CMD_IIN_OC_THRESH, 0, 0, 16'hf805);
    // Limit is 2.5 A, ten quarter-amp units: equal must not trip, one above must.
    iin_sense_q = 16'd10;
    step(2);
    chk("oc at limit", 0, 16'(input_iin_oc_fault));
    iin_sense_q = 16'd11;
    step(2);
    chk("oc above", 1, 16'(input_iin_oc_fault));
    iin_sense_q = 0;
    status_clear = 1;
    step(1);
    status_clear = 0;
    step(1);
    chk("uv unarmed", 0, 16'(input_vin_uv_fault));
    chk("oc cleared", 0, 16'(input_iin_oc_fault));
    vin_sense_q = 16'd40;
    unit_enable = 1;
    step(3);
    chk("run", 1, 16'(convert_enable));
    mask_vin_ov = 1;
    vin_ov_detect = 1;
    step(1);
    vin_ov_detect = 0;
    chk("ov alert masked", 0, 16'(host_alert_out));
    chk("ov keeps run", 1, 16'(convert_enable));
    chk("ov flag", 1, 16'(input_vin_ov_fault));
    chk("other bit", 1, 16'(status_other));
    chk("input bit", 1, 16'(status_input));
    // Event in the clear cycle: the set must win, and the unmasked flag must alert.
    mask_vin_ov = 0;
    status_clear = 1;
    vin_ov_detect = 1;
    step(1);
    status_clear = 0;
    vin_ov_detect = 0;
    chk("ov set over clear", 1, 16'(input_vin_ov_fault));
    chk("ov alert", 1, 16'(host_alert_out));
    chk("ov still run", 1, 16'(convert_enable));
    // Clear first so that the undervoltage alert below stands on its own.
    status_clear = 1;
    step(1);
    status_clear = 0;
    chk("ov cleared", 0, 16'(input_vin_ov_fault));
    chk("alert cleared", 0, 16'(host_alert_out));
    vin_sense_q = 16'd30;
    step(2);
    chk("uv flag", 1, 16'(input_vin_uv_fault));
    chk("uv alert", 1, 16'(host_alert_out));
    chk("uv off", 0, 16'(convert_enable));
    vin_sense_q = 16'd40;
    mask_vin_uv = 1;
    step(3);
    chk("uv restart", 1, 16'(convert_enable));
    chk("uv flag kept", 1, 16'(input_vin_uv_fault));
    chk("uv alert masked", 0, 16'(host_alert_out));
    nvm_oc_limit = 16'hf820;
    nvm_uv_limit = 16'hf80f;
    restore_all = 1;
    step(1);
    restore_all = 0;
    step(1);
    chk("oc restore", 16'hf820, oc_limit_out);
    chk("uv restore", 16'hf80f, uv_limit_out);
    complete_run();
  end
endmodule
`default_nettype wire
